// ===== design/smc_top.sv
// Serializer mode control: straps or registers select link mode, map, swing, self test
//
// Behaviour
// [RULE1] Each setting comes from its strap or from the control register when overridden.
// [RULE2] Mode 00 talks to same-family receiver with control filter off.
// [RULE3] Mode 01 talks to same-family receiver with control filter on.
// [RULE4] Mode 10 frames the serial stream for the first legacy receiver family.
// [RULE5] Mode 11 frames the serial stream for the older legacy receiver type.
// [RULE6] Map select 1 puts MSBs on lane four, 0 puts LSBs there.
// [RULE7] Power-down input high means normal serializing operation.
// [RULE8] Power-down input low drives both serial outputs high and stops the PLL.
// [RULE9] Control registers are held at reset values while powered down.
// [RULE10] Swing select 1 gives large output swing, 0 the low-power swing.
// [RULE11] Self-test enable 1 enters built-in self test, 0 normal operation.
// [RULE12] The system holds reserved straps low; they are only read back.
// [RULE13] Unconnected straps read as 0.
// [RULE14] Leaving power-down restarts the PLL and runs on default register values.
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_top (
	input wire logic ref_clk, // Parallel clock, 20 MHz
	input wire logic nrst, // Sync reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic [3:0] avs_address, // Avalon byte address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest, // Avalon wait
	input wire logic [1:0] mode_strap, // Compatibility mode strap
	input wire logic lane_map_sel, // Lane map strap
	input wire logic power_down_n, // Power-down strap, active low
	input wire logic swing_sel, // Output swing strap
	input wire logic [2:0] emphasis_ctrl, // De-emphasis code strap
	input wire logic self_test_en, // Self-test strap
	input wire logic [7:0] reserved_straps, // Reserved, tied low
	input wire logic [3:0] parallel_lvds_lanes, // Recovered lane bits, same clock
	output logic serial_p, // Serial true output level
	output logic serial_n, // Serial inverted output level
	output logic pll_en, // PLL running
	output logic link_active, // PLL locked, stream running
	output logic [1:0] compat_mode, // Mode in force
	output logic filter_on, // Control signal filter on
	output logic swing_hi, // Large output swing
	output logic [2:0] emphasis_out, // De-emphasis code in force
	output logic bist_active // Self test running
);
	smc_cfg_if cfg();
	smc_pkg::smc_link_st_t st;
	smc_pkg::smc_link_st_t next_st;
	logic [`SMC_CTRL_W-1:0] ctrl;
	logic [7:0] lock_cnt;
	logic [2:0] bit_cnt;
	logic [2:0] cur_len;
	logic [5:0] frame_sr;
	logic [6:0] lfsr;
	logic [3:0] lane_prev;
	logic [3:0] lane_held;
	logic [1:0] eff_mode;
	logic eff_map;
	logic eff_swing;
	logic [2:0] eff_emph;
	logic eff_bist;
	logic [3:0] data_word;
	logic word_load;
	logic bus_wr;
	logic [5:0] load_frame;

	smc_strap_sync u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		.strap_raw({reserved_straps, emphasis_ctrl, self_test_en, swing_sel,
			power_down_n, lane_map_sel, mode_strap}),
		.cfg(cfg.src)
	);

	// Frame length for a compatibility mode
	function automatic logic [2:0] frame_len(input logic [1:0] m);
		if (m == smc_pkg::SMC_MODE_LEG_A) begin
			frame_len = `SMC_LEN_LEG_A;
		end else if (m == smc_pkg::SMC_MODE_LEG_B) begin
			frame_len = `SMC_LEN_LEG_B;
		end else begin
			frame_len = `SMC_LEN_SAME;
		end
	endfunction

	// Frame left-aligned in six bits, sent MSB first
	function automatic logic [5:0] build_frame(input logic [1:0] m, input logic [3:0] d);
		if (m == smc_pkg::SMC_MODE_LEG_A) begin
			build_frame = {1'b1, d, 1'b0}; // Start bit then data
		end else if (m == smc_pkg::SMC_MODE_LEG_B) begin
			build_frame = {1'b1, d, 1'b0}; // Start and stop bit
		end else begin
			build_frame = {d, 2'h0};
		end
	endfunction

	// Strap or register source for each setting
	always_comb begin
		if (ctrl[`SMC_OVR_BIT]) begin
			eff_mode = ctrl[`SMC_MODE_HI:`SMC_MODE_LO]; // RULE1
			eff_map = ctrl[`SMC_MAP_BIT];
			eff_swing = ctrl[`SMC_SWING_BIT];
			eff_emph = ctrl[`SMC_EMPH_HI:`SMC_EMPH_LO];
			eff_bist = ctrl[`SMC_BIST_BIT];
		end else begin
			eff_mode = cfg.mode_s; // RULE1
			eff_map = cfg.map_s;
			eff_swing = cfg.swing_s;
			eff_emph = cfg.emph_s;
			eff_bist = cfg.bist_s;
		end
	end

	// Lane order: lane four MSB as is, otherwise bit-reversed; self test replaces data
	always_comb begin
		if (eff_bist) begin
			data_word = lfsr[3:0]; // RULE11
		end else if (eff_map) begin
			data_word = lane_held; // RULE6
		end else begin
			data_word = {lane_held[0], lane_held[1], lane_held[2], lane_held[3]}; // RULE6
		end
	end

	assign word_load = (st == smc_pkg::SMC_RUN) && (bit_cnt == 3'h0);
	assign bus_wr = avs_write && !avs_waitrequest && (avs_address == `SMC_CTRL_OFS);
	assign load_frame = build_frame(eff_mode, data_word);

	// Control register; forced to reset while powered down so wake-up uses defaults
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl <= `SMC_CTRL_RST;
		end else if (ce) begin
			if (!cfg.pdn_s) begin
				ctrl <= `SMC_CTRL_RST; // RULE9 RULE14
			end else if (bus_wr) begin
				ctrl <= avs_writedata[`SMC_CTRL_W-1:0];
			end
		end
	end

	// Bus answer one cycle after the request, so waitrequest comes from a flop
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// Read data captured with the request, valid while waitrequest is low
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			avs_readdata <= 32'h00000000;
		end else if (ce && avs_read && avs_waitrequest) begin
			if (avs_address == `SMC_CTRL_OFS) begin
				avs_readdata <= {23'h0, ctrl};
			end else if (avs_address == `SMC_STAT_OFS) begin
				avs_readdata <= {22'h0, eff_bist, eff_emph, eff_swing, eff_map,
					eff_mode, !cfg.pdn_s, link_active};
			end else if (avs_address == `SMC_STRAP_OFS) begin
				avs_readdata <= {15'h0, cfg.res_s, cfg.emph_s, cfg.bist_s, // RULE12
					cfg.swing_s, cfg.pdn_s, cfg.map_s, cfg.mode_s};
			end else begin
				avs_readdata <= 32'h00000000; // Unmapped reads zero
			end
		end
	end

	// Link state: off in power-down, lock wait after wake, then run
	always_comb begin
		next_st = st;
		case (st)
			smc_pkg::SMC_OFF: begin
				if (cfg.pdn_s) begin
					next_st = smc_pkg::SMC_LOCK; // RULE14
				end
			end
			smc_pkg::SMC_LOCK: begin
				if (!cfg.pdn_s) begin
					next_st = smc_pkg::SMC_OFF; // RULE8
				end else if (lock_cnt == 8'(`SMC_PLL_LOCK_CYC - 1)) begin
					next_st = smc_pkg::SMC_RUN; // RULE7
				end
			end
			default: begin
				if (!cfg.pdn_s) begin
					next_st = smc_pkg::SMC_OFF; // RULE8
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st <= smc_pkg::SMC_OFF;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Lock wait counter, cleared whenever not locking
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lock_cnt <= 8'h00;
		end else if (ce) begin
			lock_cnt <= (st == smc_pkg::SMC_LOCK) ? lock_cnt + 8'h01 : 8'h00;
		end
	end

	// Control filter: a lane change passes only once seen twice in a row
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lane_prev <= 4'h0;
			lane_held <= 4'h0;
		end else if (ce) begin
			lane_prev <= parallel_lvds_lanes;
			if (eff_mode != smc_pkg::SMC_MODE_SAME_FILT) begin
				lane_held <= parallel_lvds_lanes; // RULE2 RULE4 RULE5
			end else if (parallel_lvds_lanes == lane_prev) begin
				lane_held <= parallel_lvds_lanes; // RULE3
			end
		end
	end

	// Self-test pattern, advances once per word
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lfsr <= `SMC_LFSR_SEED;
		end else if (ce && word_load) begin
			lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
		end
	end

	// Frame shifter; mode is sampled at each word start so frames never tear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bit_cnt <= 3'h0;
			cur_len <= `SMC_LEN_SAME;
			frame_sr <= 6'h00;
		end else if (ce) begin
			if (st != smc_pkg::SMC_RUN) begin
				bit_cnt <= 3'h0;
			end else if (word_load) begin
				cur_len <= frame_len(eff_mode); // RULE4 RULE5
				frame_sr <= load_frame; // RULE4 RULE5
				bit_cnt <= frame_len(eff_mode) - 3'h1;
			end else begin
				frame_sr <= {frame_sr[4:0], 1'b0};
				bit_cnt <= bit_cnt - 3'h1;
			end
		end
	end

	// Serial levels: both high in power-down, idle low while locking
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			serial_p <= 1'b1;
			serial_n <= 1'b1;
		end else if (ce) begin
			if (next_st == smc_pkg::SMC_OFF) begin
				serial_p <= 1'b1; // RULE8
				serial_n <= 1'b1;
			end else if (st == smc_pkg::SMC_RUN) begin
				serial_p <= word_load ? load_frame[5] : frame_sr[4];
				serial_n <= word_load ? !load_frame[5] : !frame_sr[4];
			end else begin
				serial_p <= 1'b0;
				serial_n <= 1'b1;
			end
		end
	end

	// Status outputs, registered from the settings in force
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pll_en <= 1'b0;
			link_active <= 1'b0;
			compat_mode <= 2'h0;
			filter_on <= 1'b0;
			swing_hi <= 1'b0;
			emphasis_out <= 3'h0;
			bist_active <= 1'b0;
		end else if (ce) begin
			pll_en <= next_st != smc_pkg::SMC_OFF; // RULE8 RULE14
			link_active <= next_st == smc_pkg::SMC_RUN; // RULE7
			compat_mode <= eff_mode;
			filter_on <= eff_mode == smc_pkg::SMC_MODE_SAME_FILT; // RULE2 RULE3
			swing_hi <= eff_swing; // RULE10
			emphasis_out <= eff_emph;
			bist_active <= eff_bist; // RULE11
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_pd_outputs_high: assert property (ce && !cfg.pdn_s |=> serial_p && serial_n && !pll_en) // RULE8
		else $error("serial outputs not high or PLL on in power-down");
	a_pd_ctrl_reset: assert property (ce && !cfg.pdn_s |=> ctrl == `SMC_CTRL_RST) // RULE9
		else $error("control register not reset in power-down");
	a_run_needs_power: assert property (st == smc_pkg::SMC_RUN |-> $past(cfg.pdn_s)) // RULE7
		else $error("running without power-up");
	a_mode00_nofilt: assert property (ce && eff_mode == 2'h0 |=> !filter_on) // RULE2
		else $error("filter on in mode 00");
	a_mode01_filt: assert property (ce && eff_mode == 2'h1 |=> filter_on) // RULE3
		else $error("filter off in mode 01");
	a_leg_a_frame: assert property (ce && word_load && eff_mode == 2'h2
		|=> cur_len == `SMC_LEN_LEG_A && frame_sr[5]) // RULE4
		else $error("legacy A frame wrong");
	a_leg_b_frame: assert property (ce && word_load && eff_mode == 2'h3
		|=> cur_len == `SMC_LEN_LEG_B && frame_sr[5] && !frame_sr[0]) // RULE5
		else $error("legacy B frame wrong");
	a_lane_map_lsb: assert property (ce && word_load && !eff_bist && !eff_map // RULE6
		&& !eff_mode[1] |=> frame_sr[5] == $past(lane_held[0]) && frame_sr[2] == $past(lane_held[3]))
		else $error("lane map order wrong");
	a_swing_follow: assert property (ce |=> swing_hi == $past(eff_swing)) // RULE10
		else $error("swing select not applied");
	a_bist_follow: assert property (ce && eff_bist |=> bist_active) // RULE11
		else $error("self test not entered");
	a_strap_source: assert property (ce && !ctrl[`SMC_OVR_BIT] // RULE1
		|=> compat_mode == $past(cfg.mode_s))
		else $error("strap mode not applied");
	a_wake_lock: assert property (ce && st == smc_pkg::SMC_OFF && cfg.pdn_s
		|=> st == smc_pkg::SMC_LOCK && pll_en && ctrl == `SMC_CTRL_RST) // RULE14
		else $error("wake-up did not restart PLL with defaults");
	a_bus_answer: assert property (ce && (avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("bus answer late");
	c_leg_b_run: cover property (link_active && compat_mode == 2'h3);
	c_bist_run: cover property (link_active && bist_active);
	c_power_down: cover property ($fell(pll_en));
	c_ctrl_write: cover property (bus_wr);
endmodule
`default_nettype wire

// ===== design/smc_defs.svh
// Offsets, field positions, reset values and timing counts of the serializer mode control
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Register byte offsets
`define SMC_CTRL_OFS 4'h0
`define SMC_STAT_OFS 4'h4
`define SMC_STRAP_OFS 4'h8

// Control register fields
`define SMC_OVR_BIT 0
`define SMC_MODE_LO 1
`define SMC_MODE_HI 2
`define SMC_MAP_BIT 3
`define SMC_SWING_BIT 4
`define SMC_EMPH_LO 5
`define SMC_EMPH_HI 7
`define SMC_BIST_BIT 8
`define SMC_CTRL_W 9
`define SMC_CTRL_RST 9'h000

// Frame lengths per compatibility mode, bits per word
`define SMC_LEN_SAME 3'h4
`define SMC_LEN_LEG_A 3'h5
`define SMC_LEN_LEG_B 3'h6

// Self-test generator seed
`define SMC_LFSR_SEED 7'h7F

// PLL lock wait
`define SMC_CLK_PERIOD_NS 50
`define SMC_PLL_LOCK_NS 1000
`define SMC_PLL_LOCK_CYC ((`SMC_PLL_LOCK_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)

`endif

// ===== design/smc_pkg.sv
// Types shared by the serializer mode control modules
package smc_pkg;
	typedef enum logic [1:0] {
		SMC_MODE_SAME_NOFILT = 2'h0,
		SMC_MODE_SAME_FILT = 2'h1,
		SMC_MODE_LEG_A = 2'h2,
		SMC_MODE_LEG_B = 2'h3
	} smc_mode_t;
	typedef enum logic [1:0] {
		SMC_OFF,
		SMC_LOCK,
		SMC_RUN
	} smc_link_st_t;
endpackage

// ===== design/smc_cfg_if.sv
// Synchronised strap levels passed from the strap synchroniser to the top
`timescale 1ns/1ps
`default_nettype none
interface smc_cfg_if;
	logic [1:0] mode_s;
	logic map_s;
	logic pdn_s;
	logic swing_s;
	logic bist_s;
	logic [2:0] emph_s;
	logic [7:0] res_s;
	modport src(output mode_s, map_s, pdn_s, swing_s, bist_s, emph_s, res_s);
	modport dst(input mode_s, map_s, pdn_s, swing_s, bist_s, emph_s, res_s);
endinterface
`default_nettype wire

// ===== design/smc_strap_sync.sv
// Two-stage synchroniser for all strap pins
`timescale 1ns/1ps
`default_nettype none
module smc_strap_sync (
	input wire logic ref_clk, // Parallel clock
	input wire logic nrst, // Sync reset, active low
	input wire logic ce, // Clock enable
	input wire logic [16:0] strap_raw, // Raw strap pins
	smc_cfg_if.src cfg // Synchronised straps
);
	logic [16:0] meta;
	logic [16:0] sync;

	// One synchroniser per strap bit; reset to 0 like an open pin with pulldown
	genvar i;
	generate
		for (i = 0; i < 17; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					meta[i] <= 1'b0; // RULE13
					sync[i] <= 1'b0;
				end else if (ce) begin
					meta[i] <= strap_raw[i];
					sync[i] <= meta[i];
				end
			end
		end
	endgenerate

	// Unpack into named straps
	assign cfg.mode_s = sync[1:0];
	assign cfg.map_s = sync[2];
	assign cfg.pdn_s = sync[3];
	assign cfg.swing_s = sync[4];
	assign cfg.bist_s = sync[5];
	assign cfg.emph_s = sync[8:6];
	assign cfg.res_s = sync[16:9];
endmodule
`default_nettype wire

// ===== tb/smc_rx_model.sv
// Far-side receiver model: collects the serial stream and watches its polarity
`timescale 1ns/1ps
`default_nettype none
module smc_rx_model (
	input wire logic ref_clk, // Parallel clock
	input wire logic serial_p, // Serial true level
	input wire logic serial_n, // Serial inverted level
	input wire logic link_active, // Stream running
	output logic [11:0] rx_win, // Last twelve bits, newest at bit 0
	output logic [7:0] pol_err // Running cycles with equal polarities
);
	// Start clean so a stuck line shows up as a fault; one process owns both outputs
	// No frame alignment: the bench matches any phase of the word
	initial begin
		rx_win = 12'h000;
		pol_err = 8'h00;
		forever begin
			@(posedge ref_clk);
			rx_win <= {rx_win[10:0], serial_p};
			if (link_active && serial_p === serial_n) begin
				pol_err <= pol_err + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/serializer_mode_control_tb_top.sv
// Self-checking bench for the serializer mode control
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module serializer_mode_control_tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] mode_strap = 2'h0;
	logic lane_map_sel = 1'b0;
	logic power_down_n = 1'b0;
	logic swing_sel = 1'b0;
	logic [2:0] emphasis_ctrl = 3'h0;
	logic self_test_en = 1'b0;
	logic [7:0] reserved_straps = 8'h00;
	logic [3:0] parallel_lvds_lanes = 4'hC;
	logic serial_p, serial_n, pll_en, link_active, filter_on, swing_hi, bist_active;
	logic [1:0] compat_mode;
	logic [2:0] emphasis_out;
	logic [11:0] rx_win;
	logic [7:0] pol_err;
	logic [31:0] rd;
	int err_count = 0;
	int n_compared = 0;
	int cnt;
	// Free-running parallel clock
	always #25 ref_clk = ~ref_clk;
	smc_top uut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mode_strap(mode_strap), .lane_map_sel(lane_map_sel), .power_down_n(power_down_n),
		.swing_sel(swing_sel), .emphasis_ctrl(emphasis_ctrl), .self_test_en(self_test_en),
		.reserved_straps(reserved_straps), .parallel_lvds_lanes(parallel_lvds_lanes),
		.serial_p(serial_p), .serial_n(serial_n), .pll_en(pll_en), .link_active(link_active),
		.compat_mode(compat_mode), .filter_on(filter_on), .swing_hi(swing_hi),
		.emphasis_out(emphasis_out), .bist_active(bist_active));
	smc_rx_model rx (.ref_clk(ref_clk), .serial_p(serial_p), .serial_n(serial_n),
		.link_active(link_active), .rx_win(rx_win), .pol_err(pol_err));
	// Verdict and end of run
	task tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask
	// One Avalon transfer; signals sampled before this edge's updates land
	task av_access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
		int k;
		@(posedge ref_clk);
		avs_address <= addr;
		avs_writedata <= wdata;
		avs_write <= wr;
		avs_read <= ~wr;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin
			chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wait_link;
		cnt = 0;
		while (link_active !== 1'b1 && cnt < 200) begin
			@(posedge ref_clk);
			cnt++;
		end
		chk("link_active", 32'h1, {31'h0, link_active});
	endtask
	// Received bits must repeat with the frame length and match the framed word
	task chk_frame(input logic [1:0] md, input logic mp);
		logic [3:0] d;
		logic [5:0] pat;
		logic [5:0] rot;
		logic [5:0] msk;
		logic ok;
		int p;
		d = mp ? parallel_lvds_lanes : {parallel_lvds_lanes[0], parallel_lvds_lanes[1],
			parallel_lvds_lanes[2], parallel_lvds_lanes[3]};
		p = (md == 2'h3) ? 6 : ((md == 2'h2) ? 5 : 4);
		pat = (md == 2'h3) ? {1'b1, d, 1'b0} : ((md == 2'h2) ? {2'h1, d} : {2'h0, d});
		msk = 6'h3F >> (6 - p);
		ok = 1'b1;
		for (int i = 0; i + p < 12; i++) if (rx_win[i] !== rx_win[i + p]) ok = 1'b0;
		rot = 6'h00;
		for (int r = 0; r < p; r++) begin
			for (int i = 0; i < p; i++) rot[i] = pat[(i + r) % p];
			if ((rx_win[5:0] & msk) === rot) msk = 6'h00;
		end
		chk("frame", 32'h1, {31'h0, ok & (msk == 6'h00)});
	endtask
	// Hang guard, far beyond the expected run length
	initial begin
		#200000;
		$display("[ERR] watchdog expected end seen hang");
		err_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("serial_p", 32'h1, {31'h0, serial_p});
		chk("serial_n", 32'h1, {31'h0, serial_n});
		chk("pll_en", 32'h0, {31'h0, pll_en});
		av_access(1'b1, `SMC_CTRL_OFS, 32'h5F);
		av_access(1'b0, `SMC_CTRL_OFS, 32'h0);
		chk("ctrl_pd", 32'h0, rd);
		av_access(1'b0, `SMC_STRAP_OFS, 32'h0);
		chk("straps_pd", 32'h0, rd);
		power_down_n <= 1'b1;
		cnt = 0;
		while (pll_en !== 1'b1 && cnt < 20) begin
			@(posedge ref_clk);
			cnt++;
		end
		chk("pll_en", 32'h1, {31'h0, pll_en});
		cnt = 0;
		while (link_active !== 1'b1 && cnt < 100) begin
			@(posedge ref_clk);
			cnt++;
		end
		chk("lock_wait", 32'h1, {31'h0, cnt >= `SMC_PLL_LOCK_CYC - 1 &&
			cnt <= `SMC_PLL_LOCK_CYC + 1});
		// Every mode with both lane maps from the straps
		for (int m = 0; m < 8; m++) begin
			mode_strap <= m[1:0];
			lane_map_sel <= m[2];
			repeat (6) @(posedge ref_clk);
			wait_link();
			repeat (16) @(posedge ref_clk);
			chk("compat_mode", {30'h0, m[1:0]}, {30'h0, compat_mode});
			chk("filter_on", {31'h0, m[1:0] == 2'h1}, {31'h0, filter_on});
			chk_frame(m[1:0], m[2]);
		end
		chk("pol_err", 32'h0, {24'h0, pol_err});
		swing_sel <= 1'b1;
		emphasis_ctrl <= 3'h5;
		self_test_en <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("swing_hi", 32'h1, {31'h0, swing_hi});
		chk("emphasis_out", 32'h5, {29'h0, emphasis_out});
		chk("bist_active", 32'h1, {31'h0, bist_active});
		swing_sel <= 1'b0;
		emphasis_ctrl <= 3'h0;
		self_test_en <= 1'b0;
		mode_strap <= 2'h0;
		lane_map_sel <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("swing_lo", 32'h0, {31'h0, swing_hi});
		chk("bist_off", 32'h0, {31'h0, bist_active});
		// Register override: mode 11, map 1, swing 1, emphasis 2
		av_access(1'b1, `SMC_CTRL_OFS, 32'h5F);
		repeat (6) @(posedge ref_clk);
		chk("ovr_mode", 32'h3, {30'h0, compat_mode});
		chk("ovr_swing", 32'h1, {31'h0, swing_hi});
		chk("ovr_emph", 32'h2, {29'h0, emphasis_out});
		av_access(1'b0, `SMC_STAT_OFS, 32'h0);
		chk("status", 32'hBC, rd & 32'h3FE);
		wait_link();
		repeat (16) @(posedge ref_clk);
		chk_frame(2'h3, 1'b1);
		av_access(1'b0, `SMC_STRAP_OFS, 32'h0);
		chk("straps", 32'h8, rd);
		av_access(1'b1, 4'hC, 32'hFFFFFFFF);
		av_access(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, rd);
		// Power down and back up: settings fall back to defaults
		power_down_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("pd_serial_p", 32'h1, {31'h0, serial_p});
		chk("pd_serial_n", 32'h1, {31'h0, serial_n});
		chk("pd_pll_en", 32'h0, {31'h0, pll_en});
		power_down_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		av_access(1'b0, `SMC_CTRL_OFS, 32'h0);
		chk("ctrl_up", 32'h0, rd);
		chk("mode_up", 32'h0, {30'h0, compat_mode});
		wait_link();
		tally_and_finish();
	end
endmodule
`default_nettype wire
